// ### shared/ppi_defs.vh
// Purpose: constants for the parallel port and external interrupt block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   register byte address is four times the register index
`ifndef PPI_DEFS_VH
`define PPI_DEFS_VH

// register indices
`define PPI_IDX_A_DATA      4'h0
`define PPI_IDX_B_DATA      4'h1
`define PPI_IDX_C_DATA      4'h2
`define PPI_IDX_D_DATA      4'h3
`define PPI_IDX_A_DIR       4'h4
`define PPI_IDX_B_DIR       4'h5
`define PPI_IDX_C_DIR       4'h6
`define PPI_IDX_D_DIR       4'h7
`define PPI_IDX_OPTION      4'h8
`define PPI_IDX_SERIAL_CTL  4'h9
`define PPI_IDX_INT_STATUS  4'ha
`define PPI_ADDR_LSB        2
`define PPI_ADDR_MSB        5

// option register fields
`define PPI_OPT_LEVEL_BIT   1
`define PPI_OPT_RESET       8'h02

// serial control fields
`define PPI_SER_SPI_BIT     0
`define PPI_SER_ASYNC_BIT   1
`define PPI_SER_RESET       2'h0

// interrupt status fields
`define PPI_STAT_LATCH_BIT  0
`define PPI_STAT_PIN_BIT    1

// reset values
`define PPI_DIR_RESET       8'h00
`define PPI_DATA_RESET      8'h00

// fourth port: bit 6 has no line, four lines to the sync serial unit, two to async
`define PPI_D_IMPL_MASK     8'hbf
`define PPI_D_CMP_BIT       6
`define PPI_D_SPI_MASK      8'h3c
`define PPI_D_ASYNC_MASK    8'h03

// timing
`define PPI_CLK_PERIOD_NS   10
`define PPI_MIN_INT_LOW_NS  100
`define PPI_MIN_INT_LOW_CYC ((`PPI_MIN_INT_LOW_NS + `PPI_CLK_PERIOD_NS - 1) / `PPI_CLK_PERIOD_NS)
`define PPI_LOW_CNT_W       8

`endif

// ### verilog/ppi_sync.v
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: inputs are asynchronous to pclk
// Notes:   output moves only when second and third stages agree
`timescale 1ns/10ps
module ppi_sync #(
	parameter W   = 8,
	parameter RST = 0
) (
	// clock and reset
	input  wire         pclk,
	input  wire         presetn,
	// data
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] sync_out
);
	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;
	integer     i;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q     <= {W{RST[0]}};
			s2_q     <= {W{RST[0]}};
			s3_q     <= {W{RST[0]}};
			sync_out <= {W{RST[0]}};
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (i = 0; i < W; i = i + 1) begin
				if (s2_q[i] == s3_q[i]) begin
					sync_out[i] <= s3_q[i];
				end
			end
		end
	end
endmodule

// ### verilog/ppi_top.v
// Purpose: four parallel ports and external interrupt request latch, APB slave
// Assumes: pclk is the oscillator; pins are asynchronous
// Notes:   pin oe_n low means this block drives the line
`timescale 1ns/10ps
`include "ppi_defs.vh"
module ppi_top (
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output reg         pslverr,
	// first port lines
	input  wire [7:0]  first_port_lines_in,
	output wire [7:0]  first_port_lines_out,
	output wire [7:0]  first_port_lines_oe_n,
	// second port lines
	input  wire [7:0]  second_port_lines_in,
	output wire [7:0]  second_port_lines_out,
	output wire [7:0]  second_port_lines_oe_n,
	// third port lines
	input  wire [7:0]  third_port_lines_in,
	output wire [7:0]  third_port_lines_out,
	output wire [7:0]  third_port_lines_oe_n,
	// fourth port lines, bit 6 unused
	input  wire [7:0]  fourth_port_lines_in,
	output wire [7:0]  fourth_port_lines_out,
	output wire [7:0]  fourth_port_lines_oe_n,
	// timer compare pin level
	input  wire        timer_compare_out,
	// serial unit enables
	output wire        sync_serial_enable,
	output wire        async_serial_enable,
	// external interrupt and cpu side
	input  wire        ext_int_n,
	input  wire        instr_boundary,
	input  wire        cpu_int_mask,
	output reg         int_sequence_start,
	output wire        int_request,
	// divided internal clock
	output wire        internal_clk
);
	// port registers
	reg  [7:0] a_data_q;
	reg  [7:0] b_data_q;
	reg  [7:0] c_data_q;
	reg  [7:0] d_data_q;
	reg  [7:0] a_dir_q;
	reg  [7:0] b_dir_q;
	reg  [7:0] c_dir_q;
	reg  [7:0] d_dir_q;
	reg  [7:0] option_q;
	reg        option_written_q;
	reg  [1:0] serial_q;
	reg        int_latch_q;
	reg        int_latch_d;
	reg        int_armed_q;
	reg  [`PPI_LOW_CNT_W-1:0] low_cnt_q;
	reg        div_q;

	// synchronised pins
	wire [7:0] a_pin;
	wire [7:0] b_pin;
	wire [7:0] c_pin;
	wire [7:0] d_pin;
	wire       cmp_pin;
	wire       irq_pin;

	// bus decode
	wire       setup_ph;
	wire       wr_access;
	wire [3:0] idx;
	wire       addr_ok;
	reg  [7:0] rd_byte;
	reg        rd_hit;

	wire       level_mode;
	wire       low_long;
	wire [7:0] d_serial_mask;

	function [7:0] pin_or_latch;
		input [7:0] dir;
		input [7:0] latch;
		input [7:0] pin;
		begin
			pin_or_latch = (dir & latch) | (~dir & pin);
		end
	endfunction

	// high-z (oe_n high) unless direction bit set and not owned by serial
	function [7:0] drive_n;
		input [7:0] dir;
		input [7:0] owned;
		begin
			drive_n = ~(dir & ~owned);
		end
	endfunction

	// 24 lines of ports a to c, 7 of port d, compare pin, interrupt pin
	ppi_sync #(
		.W   (33),
		.RST (1)
	) ppi_sync_i (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({first_port_lines_in, second_port_lines_in, third_port_lines_in,
		            fourth_port_lines_in[7], fourth_port_lines_in[5:0], timer_compare_out,
		            ext_int_n}),
		.sync_out ({a_pin, b_pin, c_pin, d_pin[7], d_pin[5:0], cmp_pin, irq_pin})
	);
	assign d_pin[6]  = 1'b0;

	assign pready    = 1'b1;
	assign setup_ph  = psel & ~penable;
	assign wr_access = psel & penable & pwrite;
	assign idx       = paddr[`PPI_ADDR_MSB:`PPI_ADDR_LSB];
	assign addr_ok   = (paddr[31:`PPI_ADDR_MSB+1] == 26'h000_0000) &&
	                   (paddr[`PPI_ADDR_LSB-1:0] == 2'b00) && rd_hit;

	assign d_serial_mask = ({8{serial_q[`PPI_SER_SPI_BIT]}} & `PPI_D_SPI_MASK) |
	                       ({8{serial_q[`PPI_SER_ASYNC_BIT]}} & `PPI_D_ASYNC_MASK);
	assign sync_serial_enable  = serial_q[`PPI_SER_SPI_BIT];
	assign async_serial_enable = serial_q[`PPI_SER_ASYNC_BIT];

	assign first_port_lines_out   = a_data_q;
	assign second_port_lines_out  = b_data_q;
	assign third_port_lines_out   = c_data_q;
	assign fourth_port_lines_out  = d_data_q & `PPI_D_IMPL_MASK;
	assign first_port_lines_oe_n  = drive_n(a_dir_q, 8'h00);
	assign second_port_lines_oe_n = drive_n(b_dir_q, 8'h00);
	assign third_port_lines_oe_n  = drive_n(c_dir_q, 8'h00);
	assign fourth_port_lines_oe_n = drive_n(d_dir_q & `PPI_D_IMPL_MASK, d_serial_mask);

	// register read mux
	always @* begin
		rd_hit  = 1'b1;
		rd_byte = 8'h00;
		case (idx)
			`PPI_IDX_A_DATA: begin
				rd_byte = pin_or_latch(a_dir_q, a_data_q, a_pin);
			end
			`PPI_IDX_B_DATA: begin
				rd_byte = pin_or_latch(b_dir_q, b_data_q, b_pin);
			end
			`PPI_IDX_C_DATA: begin
				rd_byte = pin_or_latch(c_dir_q, c_data_q, c_pin);
			end
			`PPI_IDX_D_DATA: begin
				rd_byte = pin_or_latch(d_dir_q, d_data_q, d_pin) & `PPI_D_IMPL_MASK;
				rd_byte[`PPI_D_CMP_BIT] = cmp_pin;
			end
			`PPI_IDX_A_DIR: begin
				rd_byte = a_dir_q;
			end
			`PPI_IDX_B_DIR: begin
				rd_byte = b_dir_q;
			end
			`PPI_IDX_C_DIR: begin
				rd_byte = c_dir_q;
			end
			`PPI_IDX_D_DIR: begin
				rd_byte = d_dir_q & `PPI_D_IMPL_MASK;
			end
			`PPI_IDX_OPTION: begin
				rd_byte = option_q;
			end
			`PPI_IDX_SERIAL_CTL: begin
				rd_byte = {6'h00, serial_q};
			end
			`PPI_IDX_INT_STATUS: begin
				rd_byte[`PPI_STAT_LATCH_BIT] = int_latch_q;
				rd_byte[`PPI_STAT_PIN_BIT]   = irq_pin;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// read data and error captured in setup, shown during access
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup_ph) begin
			prdata  <= (addr_ok && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			pslverr <= ~addr_ok;
		end
	end

	// register writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_data_q         <= `PPI_DATA_RESET;
			b_data_q         <= `PPI_DATA_RESET;
			c_data_q         <= `PPI_DATA_RESET;
			d_data_q         <= `PPI_DATA_RESET;
			a_dir_q          <= `PPI_DIR_RESET;
			b_dir_q          <= `PPI_DIR_RESET;
			c_dir_q          <= `PPI_DIR_RESET;
			d_dir_q          <= `PPI_DIR_RESET;
			option_q         <= `PPI_OPT_RESET;
			option_written_q <= 1'b0;
			serial_q         <= `PPI_SER_RESET;
		end else if (wr_access && addr_ok) begin
			case (idx)
				`PPI_IDX_A_DATA: begin
					a_data_q <= pwdata[7:0];
				end
				`PPI_IDX_A_DIR: begin
					a_dir_q <= pwdata[7:0];
				end
				`PPI_IDX_B_DATA: begin
					b_data_q <= pwdata[7:0];
				end
				`PPI_IDX_B_DIR: begin
					b_dir_q <= pwdata[7:0];
				end
				`PPI_IDX_C_DATA: begin
					c_data_q <= pwdata[7:0];
				end
				`PPI_IDX_C_DIR: begin
					c_dir_q <= pwdata[7:0];
				end
				`PPI_IDX_D_DATA: begin
					d_data_q <= pwdata[7:0] & `PPI_D_IMPL_MASK;
				end
				`PPI_IDX_D_DIR: begin
					d_dir_q <= pwdata[7:0] & `PPI_D_IMPL_MASK;
				end
				// sensitivity bit may be written only once
				`PPI_IDX_OPTION: begin
					if (!option_written_q) begin
						option_q[`PPI_OPT_LEVEL_BIT] <= pwdata[`PPI_OPT_LEVEL_BIT];
						option_written_q             <= 1'b1;
					end
				end
				`PPI_IDX_SERIAL_CTL: begin
					serial_q <= pwdata[1:0];
				end
				default: begin
				end
			endcase
		end
	end

	assign level_mode = option_q[`PPI_OPT_LEVEL_BIT];
	assign low_long   = (low_cnt_q >= `PPI_MIN_INT_LOW_CYC);

	// low duration counter and edge re-arm
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_cnt_q   <= {`PPI_LOW_CNT_W{1'b0}};
			int_armed_q <= 1'b1;
		end else if (irq_pin) begin
			low_cnt_q   <= {`PPI_LOW_CNT_W{1'b0}};
			int_armed_q <= 1'b1;
		end else begin
			if (!low_long) begin
				low_cnt_q <= low_cnt_q + {{(`PPI_LOW_CNT_W-1){1'b0}}, 1'b1};
			end
			if (low_long) begin
				int_armed_q <= 1'b0;
			end
		end
	end

	// request latch next value
	always @* begin
		int_latch_d = int_latch_q;
		if (int_sequence_start) begin
			int_latch_d = 1'b0;
		end
		if (low_long && int_armed_q) begin
			int_latch_d = 1'b1;
		end
		if (low_long && level_mode) begin
			int_latch_d = 1'b1;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_latch_q        <= 1'b0;
			int_sequence_start <= 1'b0;
		end else begin
			int_latch_q        <= int_latch_d;
			int_sequence_start <= instr_boundary & int_latch_q & ~cpu_int_mask &
			                      ~int_sequence_start;
		end
	end
	assign int_request = int_latch_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 1'b0;
		end else begin
			div_q <= ~div_q;
		end
	end
	assign internal_clk = div_q;

endmodule

// ### tb/ppi_asserts.sv
// Purpose: concurrent checks on port lines, apb writes and interrupt timing
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to ppi_top below
`timescale 1ns/10ps
module ppi_asserts (
	// clock and reset
	input wire        pclk,
	input wire        presetn,
	// apb
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	// port lines
	input wire [7:0]  first_port_lines_out,
	input wire [7:0]  first_port_lines_oe_n,
	input wire [7:0]  second_port_lines_oe_n,
	input wire [7:0]  third_port_lines_oe_n,
	input wire [7:0]  fourth_port_lines_oe_n,
	// serial, interrupt, clock
	input wire        sync_serial_enable,
	input wire        async_serial_enable,
	input wire        ext_int_n,
	input wire        instr_boundary,
	input wire        cpu_int_mask,
	input wire        int_sequence_start,
	input wire        int_request,
	input wire        internal_clk
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [7:0] wd_q;
	wire        acc_w = psel && penable && pwrite;
	always_ff @(posedge pclk) wd_q <= pwdata[7:0];
	sequence held_low;
		(!ext_int_n && cpu_int_mask)[*8] ##1 (!ext_int_n && cpu_int_mask)[*8];
	endsequence
	sequence quiet_line;
		ext_int_n[*8];
	endsequence
	rst_inputs_a: assert property ($rose(presetn) |->
		&{first_port_lines_oe_n, second_port_lines_oe_n, third_port_lines_oe_n,
		fourth_port_lines_oe_n}) else $error("port line driven after reset");
	ser_off_a: assert property ($rose(presetn) |->
		!sync_serial_enable && !async_serial_enable) else $error("serial unit on");
	dir_write_a: assert property (acc_w && paddr == 32'h0000_0010 |=>
		first_port_lines_oe_n == ~wd_q) else $error("direction write not applied");
	data_write_a: assert property (acc_w && paddr == 32'h0000_0000 |=>
		first_port_lines_out == wd_q) else $error("data write not latched");
	latch_read_a: assert property (psel && !penable && !pwrite &&
		paddr == 32'h0000_0000 && first_port_lines_oe_n == 8'h00 |=>
		prdata[7:0] == $past(first_port_lines_out)) else $error("read not latch");
	int_start_a: assert property (instr_boundary && int_request &&
		!cpu_int_mask && !int_sequence_start |=> int_sequence_start)
		else $error("service not started");
	start_cause_a: assert property (int_sequence_start |-> $past(instr_boundary) &&
		$past(int_request) && !$past(cpu_int_mask)) else $error("unwanted service");
	one_pulse_a: assert property (quiet_line ##0 int_sequence_start |=>
		!int_sequence_start && !int_request) else $error("request not cleared");
	low_sets_a: assert property ($fell(ext_int_n) ##1 held_low |->
		##[0:4] int_request) else $error("low input not latched");
	clk_div_a: assert property ($past(presetn) |->
		internal_clk != $past(internal_clk)) else $error("internal clock stuck");
endmodule
bind ppi_top ppi_asserts ppi_asserts_i (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .first_port_lines_out, .first_port_lines_oe_n,
	.second_port_lines_oe_n, .third_port_lines_oe_n, .fourth_port_lines_oe_n,
	.sync_serial_enable, .async_serial_enable, .ext_int_n, .instr_boundary,
	.cpu_int_mask, .int_sequence_start, .int_request, .internal_clk);

// ### tb/ppi_pins_model.sv
// Purpose: outside circuitry on one port's lines
// Assumes: the block drives a line only while its oe_n is low
// Notes:   lines left free show the level the bench sets
`timescale 1ns/10ps
module ppi_pins_model (
	// block side
	input  wire [7:0] out,
	input  wire [7:0] oe_n,
	// bench side
	input  wire [7:0] ext,
	output wire [7:0] lvl
);
	assign lvl = (~oe_n & out) | (oe_n & ext);
endmodule

// ### tb/tb_ppi_top.sv
// Purpose: self-checking bench for the parallel ports and interrupt latch
// Assumes: pin levels settle well before the data read
// Notes:   random port values from a fixed seed
`timescale 1ns/10ps
`include "ppi_defs.vh"
module tb_ppi_top;
	logic        pclk, presetn, psel, penable, pwrite, cmp_lvl, er, st;
	logic        ext_int_n, instr_boundary, cpu_int_mask;
	logic [31:0] paddr, pwdata, rd;
	logic [7:0]  ext[4];
	logic [7:0]  dv, dm, mk;
	wire  [7:0]  po[4], pe[4], pl[4];
	wire  [31:0] prdata;
	wire         pready, pslverr, ssen, asen, istart, ireq;
	integer      seed, n_fail, check_count, p;

	ppi_top ppi_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .first_port_lines_in(pl[0]),
		.first_port_lines_out(po[0]), .first_port_lines_oe_n(pe[0]),
		.second_port_lines_in(pl[1]), .second_port_lines_out(po[1]),
		.second_port_lines_oe_n(pe[1]), .third_port_lines_in(pl[2]),
		.third_port_lines_out(po[2]), .third_port_lines_oe_n(pe[2]),
		.fourth_port_lines_in(pl[3]), .fourth_port_lines_out(po[3]),
		.fourth_port_lines_oe_n(pe[3]), .timer_compare_out(cmp_lvl),
		.sync_serial_enable(ssen), .async_serial_enable(asen), .ext_int_n,
		.instr_boundary, .cpu_int_mask, .int_sequence_start(istart),
		.int_request(ireq), .internal_clk());
	for (genvar g = 0; g < 4; g++) begin : pm
		ppi_pins_model ppi_pins_model_i (.out(po[g]), .oe_n(pe[g]), .ext(ext[g]),
			.lvl(pl[g]));
	end

	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end

	task automatic chk(input string nm, input logic [31:0] exp, got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [31:0] a, d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask

	// start pulse stands one cycle: sampled mid-cycle after the boundary edge
	task automatic service(input logic m, output logic s);
		instr_boundary <= 1'h1;
		cpu_int_mask <= m;
		@(posedge pclk);
		instr_boundary <= 1'h0;
		cpu_int_mask <= 1'h1;
		@(negedge pclk);
		s = istart;
		@(posedge pclk);
	endtask

	function automatic logic [7:0] rd_exp(input logic [7:0] m, v, e, input integer q);
		rd_exp = (m & v) | (~m & e);
		if (q == 3) rd_exp = (rd_exp & `PPI_D_IMPL_MASK) | {1'h0, cmp_lvl, 6'h00};
	endfunction

	task final_report;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		final_report;
	end

	initial begin
		seed = 13;
		n_fail = 0;
		check_count = 0;
		{presetn, psel, penable, pwrite, cmp_lvl, instr_boundary} = 6'h00;
		{ext_int_n, cpu_int_mask} = 2'h3;
		{paddr, pwdata} = 64'h0000_0000_0000_0000;
		for (p = 0; p < 4; p++) ext[p] = 8'h00;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		chk("serial", 2'h0, {ssen, asen});
		for (p = 0; p < 4; p++) begin
			chk("oe_n", 8'hff, pe[p]);
			apb(1'h0, 32'(16 + 4 * p), 32'h0000_0000);
			chk("dir", 8'h00, rd);
		end
		// ports: A all outputs, B all inputs, C and D random
		for (p = 0; p < 4; p++) begin
			dv = $random(seed);
			dm = (p == 0) ? 8'hff : (p == 1) ? 8'h00 : 8'($random(seed));
			mk = (p == 3) ? `PPI_D_IMPL_MASK : 8'hff;
			ext[p] <= $random(seed);
			cmp_lvl <= $random(seed);
			apb(1'h1, 32'(4 * p), {24'h00_0000, dv});
			chk("out", dv & mk, po[p]);
			chk("oe_n", 8'hff, pe[p]);
			apb(1'h1, 32'(16 + 4 * p), {24'h00_0000, dm});
			chk("oe_n", 8'(~(dm & mk)), pe[p]);
			apb(1'h0, 32'(16 + 4 * p), 32'h0000_0000);
			chk("dir", dm & mk, rd);
			apb(1'h0, 32'(4 * p), 32'h0000_0000);
			chk("data", rd_exp(dm & mk, dv, ext[p], p), rd);
		end
		apb(1'h0, 32'h0000_002c, 32'h0000_0000);
		chk("slverr", 1'h1, er);
		apb(1'h0, 32'h0000_0020, 32'h0000_0000);
		chk("option", 8'h02, rd);
		// level mode: held low keeps requesting
		ext_int_n <= 1'h0;
		repeat (20) @(posedge pclk);
		chk("request", 1'h1, ireq);
		service(1'h1, st);
		chk("masked", 1'h0, st);
		service(1'h0, st);
		chk("start", 1'h1, st);
		repeat (3) @(posedge pclk);
		chk("relatch", 1'h1, ireq);
		ext_int_n <= 1'h1;
		repeat (8) @(posedge pclk);
		service(1'h0, st);
		chk("start", 1'h1, st);
		@(posedge pclk);
		chk("cleared", 1'h0, ireq);
		// edge mode: one request per low period
		apb(1'h1, 32'h0000_0020, 32'h0000_0000);
		ext_int_n <= 1'h0;
		repeat (20) @(posedge pclk);
		chk("request", 1'h1, ireq);
		service(1'h0, st);
		chk("start", 1'h1, st);
		repeat (3) @(posedge pclk);
		chk("edge_only", 1'h0, ireq);
		ext_int_n <= 1'h1;
		repeat (2) @(posedge pclk);
		// serial units take their fourth port lines
		apb(1'h1, 32'h0000_0024, 32'h0000_0003);
		chk("serial", 2'h3, {ssen, asen});
		chk("oe_n", 8'(~(dm & mk & ~(`PPI_D_SPI_MASK | `PPI_D_ASYNC_MASK))), pe[3]);
		// second reset in mid-run
		presetn <= 1'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		chk("serial", 2'h0, {ssen, asen});
		for (p = 0; p < 4; p++) begin
			chk("oe_n", 8'hff, pe[p]);
		end
		apb(1'h0, 32'h0000_0020, 32'h0000_0000);
		chk("option", 8'h02, rd);
		final_report;
	end
endmodule
